// >>> include/spm_regs.svh
// Register offsets, field positions, reset values and timing counts for
// the serial port 0 and upper address pin routing block.
// Assumes a 16-bit word-addressed IO space and a 16-bit register bus.
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH

// Word offsets in the IO space.
`define SPM_ROUTE_OFS      16'h1c00
`define SPM_BOOT_OFS       16'h1c7e

// Field positions inside the routing register.
`define SPM_CLK_BIT        15
`define SPM_SP0_HI         9
`define SPM_SP0_LO         8
`define SPM_ADDR_HI        5
`define SPM_ADDR_LO        2

// Field position of the capture flag in the boot readback word.
`define SPM_BOOT_DONE_BIT  15

// Reset values of the writable fields.
`define SPM_CLK_RST        1'h0
`define SPM_SP0_RST        2'h0
`define SPM_ADDR_RST       4'hf

// Clock edges after reset release at which the boot pins are sampled.
`define SPM_BOOT_DELAY     4'ha
`define SPM_CNT_STEP       4'h1

`endif

// >>> include/spm_pkg.sv
// Types shared by the pin routing block and its serial port 0 multiplexer leaf.
// Assumes spm_regs.svh is included by every file that needs constants.
package spm_pkg;

  // Serial port 0 routing choice, in field encoding order 00 to 11.
  typedef enum logic [1:0] {
    SP0_CARD,
    SP0_AUDIO,
    SP0_GPIO,
    SP0_BSP
  } spm_sp0_mode_t;

  // Boot pin capture sequence after reset.
  typedef enum logic {
    BOOT_WAIT,
    BOOT_DONE
  } spm_boot_state_t;

endpackage

// >>> src/spm_sp0_mux.sv
// Combinational selector between the four functions of serial port 0.
// Assumes the caller registers every output before it reaches a pin.
module spm_sp0_mux (
  // Routing choice.
  input  wire spm_pkg::spm_sp0_mode_t mode,
  input  wire logic                   clk_choice,
  // Function side drives.
  input  wire logic [5:0]             card_out,
  input  wire logic [5:0]             card_oe,
  input  wire logic [3:0]             audio_out,
  input  wire logic [3:0]             audio_oe,
  input  wire logic [5:0]             gpio_out,
  input  wire logic [5:0]             gpio_oe,
  input  wire logic [5:0]             bsp_out,
  input  wire logic [5:0]             bsp_oe,
  // Pin side.
  input  wire logic [5:0]             pin_in,
  output logic      [5:0]             pin_out,
  output logic      [5:0]             pin_oe,
  // Function side receives.
  output logic      [5:0]             card_in,
  output logic      [3:0]             audio_in,
  output logic      [5:0]             gpio_in,
  output logic      [5:0]             bsp_in,
  output logic                        bsp_clks_in
);
  import spm_pkg::*;

  // Unselected functions see zero so that no stale pin level leaks in.
  always_comb begin
    pin_out     = 6'h00;
    pin_oe      = 6'h00;
    card_in     = 6'h00;
    audio_in    = 4'h0;
    gpio_in     = 6'h00;
    bsp_in      = 6'h00;
    bsp_clks_in = 1'b0;
    unique case (mode)
      SP0_CARD: begin
        pin_out = card_out;
        pin_oe  = card_oe;
        card_in = pin_in;
      end
      SP0_AUDIO: begin
        pin_out = {gpio_out[5:4], audio_out};
        pin_oe  = {gpio_oe[5:4], audio_oe};
        audio_in = pin_in[3:0];
        gpio_in  = {pin_in[5:4], 4'h0};
      end
      SP0_GPIO: begin
        pin_out = gpio_out;
        pin_oe  = gpio_oe;
        gpio_in = pin_in;
      end
      SP0_BSP: begin
        // The shared pin carries either the receive clock or the source.
        if (clk_choice) begin
          pin_out     = {1'b0, bsp_out[4:0]};
          pin_oe      = {1'b0, bsp_oe[4:0]};
          bsp_in      = {1'b0, pin_in[4:0]};
          bsp_clks_in = pin_in[5];
        end else begin
          pin_out = bsp_out;
          pin_oe  = bsp_oe;
          bsp_in  = pin_in;
        end
      end
    endcase
  end

endmodule

// >>> src/spm_addr_mux.sv
// Combinational selector for the four upper address pins.
// Assumes the caller registers every output before it reaches a pin.
module spm_addr_mux (
  // Per-pin choice, one selects the general-purpose function.
  input  wire logic [3:0] sel,
  // Forces general-purpose pins to input while the straps are sampled.
  input  wire logic       gp_hold,
  // Address and general-purpose drives.
  input  wire logic [3:0] addr_out,
  input  wire logic [3:0] gp_out,
  input  wire logic [3:0] gp_oe,
  // Pin side and general-purpose receive.
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_out,
  output logic      [3:0] pin_oe,
  output logic      [3:0] gp_in
);

  // Each pin is chosen on its own bit; index 3 is address 20.
  always_comb begin
    pin_out = 4'h0;
    pin_oe  = 4'h0;
    gp_in   = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        pin_out[i] = gp_out[i];
        pin_oe[i]  = gp_oe[i] & ~gp_hold;
        gp_in[i]   = pin_in[i];
      end else begin
        pin_out[i] = addr_out[i];
        pin_oe[i]  = 1'b1;
      end
    end
  end

endmodule

// >>> src/spm_pin_route.sv
// Pin routing block for serial port 0 and upper external address pins,
// with its routing register, boot strap capture and readback.
// Assumes a single clock, a synchronous active-low reset, inputs that
// are already synchronous to clk, and a simple strobe register port.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`include "spm_regs.svh"

module spm_pin_route #(
  parameter int AW = 16
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          rst_n,
  // Register port.
  input  wire logic [AW-1:0] reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  // Memory card function.
  input  wire logic [5:0]    card_out,
  input  wire logic [5:0]    card_oe,
  output logic      [5:0]    card_in,
  // Audio serial function.
  input  wire logic [3:0]    audio_out,
  input  wire logic [3:0]    audio_oe,
  output logic      [3:0]    audio_in,
  // General-purpose pins 5 to 0.
  input  wire logic [5:0]    gpio_out,
  input  wire logic [5:0]    gpio_oe,
  output logic      [5:0]    gpio_in,
  // Buffered serial function.
  input  wire logic [5:0]    bsp_out,
  input  wire logic [5:0]    bsp_oe,
  output logic      [5:0]    bsp_in,
  output logic               bsp_clks_in,
  // Serial port 0 pins.
  input  wire logic [5:0]    sp0_pin_in,
  output logic      [5:0]    sp0_pin_out,
  output logic      [5:0]    sp0_pin_oe,
  // Memory address 20 to 17 and general-purpose pins 26 to 23.
  input  wire logic [3:0]    ext_mem_addr_out,
  input  wire logic [3:0]    gp_hi_out,
  input  wire logic [3:0]    gp_hi_oe,
  output logic      [3:0]    gp_hi_in,
  // Upper address pins.
  input  wire logic [3:0]    addr_pin_in,
  output logic      [3:0]    addr_pin_out,
  output logic      [3:0]    addr_pin_oe,
  // Boot method straps.
  output logic      [3:0]    boot_method,
  output logic               boot_done
);
  import spm_pkg::*;

  // True when the bus address selects the given word.
  function automatic logic spm_hit(input logic [AW-1:0] a,
                                   input logic [15:0]   ofs);
    spm_hit = (a == AW'(ofs));
  endfunction

  // Packs the stored fields into the readback word.
  function automatic logic [15:0] spm_pack(input logic          ck,
                                           input spm_sp0_mode_t m,
                                           input logic [3:0]    s);
    logic [15:0] w;
    w = 16'h0000;
    w[`SPM_CLK_BIT]               = ck;
    w[`SPM_SP0_HI:`SPM_SP0_LO]    = m;
    w[`SPM_ADDR_HI:`SPM_ADDR_LO]  = s;
    spm_pack = w;
  endfunction

  // Routing register fields and their next values.
  logic              clk_choice_ff;   // Shared clock pin choice.
  logic              nxt_clk_choice;
  spm_sp0_mode_t     sp0_mode_ff;     // Serial port 0 routing.
  spm_sp0_mode_t     nxt_sp0_mode;
  logic [3:0]        addr_sel_ff;     // One bit per upper address pin.
  logic [3:0]        nxt_addr_sel;

  // Read data register and its next value.
  logic [15:0]       rdata_ff;
  logic [15:0]       nxt_rdata;

  // Boot capture sequence.
  spm_boot_state_t   boot_state_ff;
  spm_boot_state_t   nxt_boot_state;
  logic [3:0]        boot_cnt_ff;     // Edges seen since reset release, held at ten after the capture.
  logic [3:0]        nxt_boot_cnt;
  logic [3:0]        boot_method_ff;  // Latched strap levels.
  logic [3:0]        nxt_boot_method;

  // Leaf outputs, registered below before they reach any port.
  logic [5:0]        mx_sp0_out;
  logic [5:0]        mx_sp0_oe;
  logic [5:0]        mx_card_in;
  logic [3:0]        mx_audio_in;
  logic [5:0]        mx_gpio_in;
  logic [5:0]        mx_bsp_in;
  logic              mx_bsp_clks;
  logic [3:0]        mx_addr_out;
  logic [3:0]        mx_addr_oe;
  logic [3:0]        mx_gp_hi_in;

  // Registered pin and function side values.
  logic [5:0]        sp0_out_ff;
  logic [5:0]        sp0_oe_ff;
  logic [5:0]        card_in_ff;
  logic [3:0]        audio_in_ff;
  logic [5:0]        gpio_in_ff;
  logic [5:0]        bsp_in_ff;
  logic              bsp_clks_ff;
  logic [3:0]        addr_out_ff;
  logic [3:0]        addr_oe_ff;
  logic [3:0]        gp_hi_in_ff;

  // General-purpose pins stay inputs until the straps are taken.
  logic              gp_hold;

  // Register write decode. Only the routing word is writable; the
  // reserved bits and the fields kept by other blocks are dropped here.
  always_comb begin
    nxt_clk_choice = clk_choice_ff;
    nxt_sp0_mode   = sp0_mode_ff;
    nxt_addr_sel   = addr_sel_ff;
    if (reg_wr && spm_hit(reg_addr, `SPM_ROUTE_OFS)) begin
      nxt_clk_choice = reg_wdata[`SPM_CLK_BIT];
      nxt_sp0_mode   =
        spm_sp0_mode_t'(reg_wdata[`SPM_SP0_HI:`SPM_SP0_LO]);
      // Bits 7:6 have no storage, so writing them changes nothing.
      nxt_addr_sel   = reg_wdata[`SPM_ADDR_HI:`SPM_ADDR_LO];
    end
  end

  // Routing register storage with its reset values.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_choice_ff <= `SPM_CLK_RST;
      sp0_mode_ff   <= spm_sp0_mode_t'(`SPM_SP0_RST);
      addr_sel_ff   <= `SPM_ADDR_RST;
    end else begin
      clk_choice_ff <= nxt_clk_choice;
      sp0_mode_ff   <= nxt_sp0_mode;
      addr_sel_ff   <= nxt_addr_sel;
    end
  end

  // Read decode. An unmapped address and an idle cycle both give zero.
  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_rd) begin
      if (spm_hit(reg_addr, `SPM_ROUTE_OFS)) begin
        // Reserved bits 7:6 are never set by the packer.
        nxt_rdata = spm_pack(clk_choice_ff, sp0_mode_ff,
                             addr_sel_ff);
      end else if (spm_hit(reg_addr, `SPM_BOOT_OFS)) begin
        nxt_rdata                     = {12'h000, boot_method_ff};
        nxt_rdata[`SPM_BOOT_DONE_BIT] = (boot_state_ff == BOOT_DONE);
      end
    end
  end

  // Read data register; the word stands only in the cycle after a read.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Boot strap capture. The counter starts at the first edge after reset
  // release and the pins are latched on the tenth. The straps are read
  // raw, so a board must hold them steady over that window.
  always_comb begin
    nxt_boot_state  = boot_state_ff;
    nxt_boot_cnt    = boot_cnt_ff;
    nxt_boot_method = boot_method_ff;
    unique case (boot_state_ff)
      BOOT_WAIT: begin
        nxt_boot_cnt = boot_cnt_ff + `SPM_CNT_STEP;
        if (nxt_boot_cnt == `SPM_BOOT_DELAY) begin
          nxt_boot_method = addr_pin_in;
          nxt_boot_state  = BOOT_DONE;
        end
      end
      BOOT_DONE: begin
        // Latched value holds until the next reset.
        nxt_boot_cnt = boot_cnt_ff;
      end
    endcase
  end

  // Boot capture storage.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_state_ff  <= BOOT_WAIT;
      boot_cnt_ff    <= 4'h0;
      boot_method_ff <= 4'h0;
    end else begin
      boot_state_ff  <= nxt_boot_state;
      boot_cnt_ff    <= nxt_boot_cnt;
      boot_method_ff <= nxt_boot_method;
    end
  end

  // General-purpose drivers are held off until the straps are taken,
  // so the pins stay inputs from reset through the capture.
  assign gp_hold = (boot_state_ff == BOOT_WAIT);

  // The leaves see the next routing values, so the pins follow a write
  // on the very next cycle even though every port is registered. The
  // data themselves pass with one cycle of latency.
  spm_sp0_mux u_sp0 (
    .mode        (nxt_sp0_mode),
    .clk_choice  (nxt_clk_choice),
    .card_out    (card_out),
    .card_oe     (card_oe),
    .audio_out   (audio_out),
    .audio_oe    (audio_oe),
    .gpio_out    (gpio_out),
    .gpio_oe     (gpio_oe),
    .bsp_out     (bsp_out),
    .bsp_oe      (bsp_oe),
    .pin_in      (sp0_pin_in),
    .pin_out     (mx_sp0_out),
    .pin_oe      (mx_sp0_oe),
    .card_in     (mx_card_in),
    .audio_in    (mx_audio_in),
    .gpio_in     (mx_gpio_in),
    .bsp_in      (mx_bsp_in),
    .bsp_clks_in (mx_bsp_clks)
  );

  // Upper address pin selector, fed the same way.
  spm_addr_mux u_addr (
    .sel      (nxt_addr_sel),
    .gp_hold  (gp_hold),
    .addr_out (ext_mem_addr_out),
    .gp_out   (gp_hi_out),
    .gp_oe    (gp_hi_oe),
    .pin_in   (addr_pin_in),
    .pin_out  (mx_addr_out),
    .pin_oe   (mx_addr_oe),
    .gp_in    (mx_gp_hi_in)
  );

  // Pin register. No glitch guard is built in: a function switched while
  // running may see a partial transfer, which is why its clock must be
  // gated before the change and the function reset afterwards.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sp0_out_ff  <= 6'h00;
      sp0_oe_ff   <= 6'h00;
      card_in_ff  <= 6'h00;
      audio_in_ff <= 4'h0;
      gpio_in_ff  <= 6'h00;
      bsp_in_ff   <= 6'h00;
      bsp_clks_ff <= 1'b0;
      addr_out_ff <= 4'h0;
      addr_oe_ff  <= 4'h0;
      gp_hi_in_ff <= 4'h0;
    end else begin
      sp0_out_ff  <= mx_sp0_out;
      sp0_oe_ff   <= mx_sp0_oe;
      card_in_ff  <= mx_card_in;
      audio_in_ff <= mx_audio_in;
      gpio_in_ff  <= mx_gpio_in;
      bsp_in_ff   <= mx_bsp_in;
      bsp_clks_ff <= mx_bsp_clks;
      addr_out_ff <= mx_addr_out;
      addr_oe_ff  <= mx_addr_oe;
      gp_hi_in_ff <= mx_gp_hi_in;
    end
  end

  // Every output comes straight from a flip-flop.
  assign reg_rdata    = rdata_ff;
  assign sp0_pin_out  = sp0_out_ff;
  assign sp0_pin_oe   = sp0_oe_ff;
  assign card_in      = card_in_ff;
  assign audio_in     = audio_in_ff;
  assign gpio_in      = gpio_in_ff;
  assign bsp_in       = bsp_in_ff;
  assign bsp_clks_in  = bsp_clks_ff;
  assign addr_pin_out = addr_out_ff;
  assign addr_pin_oe  = addr_oe_ff;
  assign gp_hi_in     = gp_hi_in_ff;
  assign boot_method  = boot_method_ff;
  assign boot_done    = (boot_state_ff == BOOT_DONE) ? 1'b1 : 1'b0;

endmodule

// >>> bench/spm_pin_route_asserts.sv
// Concurrent checks on the pin routing block, seen from its top ports.
// Assumes one clock and a synchronous active-low reset on that clock.
`include "spm_regs.svh"

module spm_pin_route_asserts #(
  parameter int AW = 16
) (
  // Clock, reset and register port.
  input wire logic          clk,
  input wire logic          rst_n,
  input wire logic [AW-1:0] reg_addr,
  input wire logic [15:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [15:0]   reg_rdata,
  // Function side drives and receives.
  input wire logic [5:0]    card_out,
  input wire logic [5:0]    card_oe,
  input wire logic [3:0]    audio_out,
  input wire logic [5:0]    gpio_out,
  input wire logic [5:0]    bsp_out,
  input wire logic          bsp_clks_in,
  // Serial port 0 pins.
  input wire logic [5:0]    sp0_pin_in,
  input wire logic [5:0]    sp0_pin_out,
  input wire logic [5:0]    sp0_pin_oe,
  // Upper address pins and boot straps.
  input wire logic [3:0]    ext_mem_addr_out,
  input wire logic [3:0]    gp_hi_out,
  input wire logic [3:0]    addr_pin_in,
  input wire logic [3:0]    addr_pin_out,
  input wire logic [3:0]    addr_pin_oe,
  input wire logic [3:0]    boot_method,
  input wire logic          boot_done
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] mode_ff, nxt_mode;  // Shadow of the serial port 0 field.
  logic       clks_ff, nxt_clks;  // Shadow of the clock-source bit.
  logic [3:0] sel_ff, nxt_sel;    // Shadow of the address pin choices.
  logic [3:0] cnt_ff, nxt_cnt;    // Edges since reset, saturating.
  logic       wr_rt;              // A write to the routing word.

  // The shadow lets the checker know the mux without peeking inside.
  always_comb begin
    wr_rt    = reg_wr && (reg_addr == `SPM_ROUTE_OFS);
    nxt_mode = wr_rt ? reg_wdata[9:8] : mode_ff;
    nxt_clks = wr_rt ? reg_wdata[15] : clks_ff;
    nxt_sel  = wr_rt ? reg_wdata[5:2] : sel_ff;
    nxt_cnt  = (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
  end

  // Registers only; reset loads the documented defaults.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= 2'h0;
      clks_ff <= 1'h0;
      sel_ff  <= 4'hf;
      cnt_ff  <= 4'h0;
    end else begin
      mode_ff <= nxt_mode;
      clks_ff <= nxt_clks;
      sel_ff  <= nxt_sel;
      cnt_ff  <= nxt_cnt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  // The bench lifts reset on a clock edge, after the block has already
  // taken that edge as a reset one. The edge counter is still zero then,
  // so the checks stay off until the first edge the block runs normally.
  default disable iff (!rst_n || cnt_ff == 4'h0);

  AST_CARD: assert property (
    mode_ff == 2'h0 && !reg_wr |=> sp0_pin_out == $past(card_out)
    && sp0_pin_oe == $past(card_oe)) else $error("card routing wrong");
  AST_AUDIO: assert property (
    mode_ff == 2'h1 && !reg_wr |=> sp0_pin_out[3:0] == $past(audio_out)
    && sp0_pin_out[5:4] == $past(gpio_out[5:4]))
    else $error("audio routing wrong");
  AST_GPIO: assert property (
    mode_ff == 2'h2 && !reg_wr |=> sp0_pin_out == $past(gpio_out))
    else $error("gpio routing wrong");
  AST_BSP: assert property (
    mode_ff == 2'h3 && !clks_ff && !reg_wr |=>
    sp0_pin_out == $past(bsp_out) && !bsp_clks_in)
    else $error("buffered port routing wrong");
  AST_CLKS: assert property (
    mode_ff == 2'h3 && clks_ff && !reg_wr |=>
    bsp_clks_in == $past(sp0_pin_in[5]) && !sp0_pin_oe[5])
    else $error("shared clock pin wrong");
  AST_ADDR: assert property (
    !reg_wr |=> ((addr_pin_out ^ $past(ext_mem_addr_out))
    & ~$past(sel_ff)) == 4'h0 && (addr_pin_oe | $past(sel_ff)) == 4'hf)
    else $error("address pin wrong");
  AST_GPHI: assert property (
    !reg_wr |=> ((addr_pin_out ^ $past(gp_hi_out)) & $past(sel_ff)) == 4'h0)
    else $error("upper gpio pin wrong");
  AST_HOLD: assert property (
    cnt_ff < 4'ha |-> (addr_pin_oe & sel_ff) == 4'h0)
    else $error("gpio pin driven before capture");
  AST_BOOT_TIME: assert property (
    boot_done == (cnt_ff >= 4'ha)) else $error("capture at wrong edge");
  AST_BOOT_LATCH: assert property (
    $rose(boot_done) |-> boot_method == $past(addr_pin_in))
    else $error("straps latched wrong");
  AST_READ: assert property (
    reg_rd && reg_addr == `SPM_ROUTE_OFS |=> reg_rdata == {$past(clks_ff),
    5'h0, $past(mode_ff), 2'h0, $past(sel_ff), 2'h0})
    else $error("routing readback wrong");
  AST_NEXT: assert property (
    wr_rt && reg_wdata[9:8] == 2'h2 |=> sp0_pin_out == $past(gpio_out))
    else $error("routing change late");
endmodule

bind spm_pin_route spm_pin_route_asserts #(.AW(AW)) u_chk (.*);

// >>> bench/tb_spm_pin_route.sv
// Self-checking bench for the pin routing block.
// Assumes the block and its checker are compiled before this file.
module tb_spm_pin_route;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, bsp_clks_in, boot_done;
  logic [5:0]  card_out, card_oe, card_in, gpio_out, gpio_oe, gpio_in;
  logic [5:0]  bsp_out, bsp_oe, bsp_in, sp0_pin_in, sp0_pin_out, sp0_pin_oe;
  logic [3:0]  audio_out, audio_oe, audio_in, ext_mem_addr_out, gp_hi_out;
  logic [3:0]  gp_hi_oe, gp_hi_in, addr_pin_in, addr_pin_out, addr_pin_oe;
  logic [3:0]  boot_method;
  int          failures = 0;
  int          n_checks = 0;
  int          cyc = 0;

  spm_pin_route #(.AW(16)) u_dut (.*);

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // The tests need under a hundred cycles; a hang ends the run here.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end

  // All results are widened to one word so one compare serves them all.
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One-cycle write strobe; it returns just after the taking edge.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // The read word stands only in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    cmp(32'(reg_rdata), 32'(exp));
  endtask

  // Reset for four cycles with straps s, then watch the capture edge.
  task automatic t_boot(input logic [3:0] s);
    @(posedge clk);
    rst_n       <= 1'b0;
    addr_pin_in <= s;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (9) @(posedge clk);
    #1;
    cmp(32'({boot_done, addr_pin_oe}), 32'h0);
    @(posedge clk);
    #1;
    cmp(32'({boot_done, boot_method}), 32'({1'b1, s}));
    @(posedge clk);
    addr_pin_in <= ~s;
    rd(16'h1c7e, {12'h800, s});
    rd(16'h1c00, 16'h003c);
  endtask

  // Every serial port 0 mode, then mode 3 with the clock-source pin.
  task automatic t_modes();
    logic [11:0] ep;
    logic [22:0] ef, g;
    logic [5:0]  p;
    for (int n = 0; n < 2; n++) begin
      for (int k = 0; k < 5; k++) begin
        // Function drives stand still across each change, as if gated.
        wr(16'h1c00, (k == 4) ? 16'h833c : 16'h003c | 16'(k << 8));
        #1;
        p = sp0_pin_in;
        case (k)
          0: ep = {card_oe, card_out};
          1: ep = {gpio_oe[5:4], audio_oe, gpio_out[5:4], audio_out};
          2: ep = {gpio_oe, gpio_out};
          3: ep = {bsp_oe, bsp_out};
          default: ep = {1'b0, bsp_oe[4:0], 1'b0, bsp_out[4:0]};
        endcase
        case (k)
          0: ef = {p, 17'h0};
          1: ef = {6'h0, p[3:0], p[5:4], 4'h0, 7'h0};
          2: ef = {10'h0, p, 7'h0};
          3: ef = {16'h0, p, 1'b0};
          default: ef = {16'h0, 1'b0, p[4:0], p[5]};
        endcase
        g = {card_in, audio_in, gpio_in, bsp_in, bsp_clks_in};
        cmp(32'({sp0_pin_oe, sp0_pin_out}), 32'(ep));
        cmp(32'(g), 32'(ef));
      end
      // The second pass repeats the walk with the data and pin patterns inverted; enables stay.
      @(posedge clk);
      card_out   <= ~card_out;
      audio_out  <= ~audio_out;
      gpio_out   <= ~gpio_out;
      bsp_out    <= ~bsp_out;
      sp0_pin_in <= ~sp0_pin_in;
    end
  endtask

  // Reserved bits and foreign addresses must not disturb the word.
  task automatic t_regs();
    wr(16'h1c00, 16'hffff);
    rd(16'h1c00, 16'h833c);
    wr(16'h1c01, 16'h0000);
    rd(16'h1c00, 16'h833c);
    rd(16'h1c01, 16'h0000);
  endtask

  // Each address pin is flipped between address and general-purpose use.
  task automatic t_addr();
    logic [3:0] s;
    logic [7:0] e;
    for (int i = 0; i < 5; i++) begin
      s = 4'hf >> i;
      @(posedge clk);
      ext_mem_addr_out <= ~ext_mem_addr_out;
      gp_hi_oe         <= ~gp_hi_oe;
      wr(16'h1c00, 16'(s) << 2);
      #1;
      e[7:4] = ~s | (gp_hi_oe & s);
      e[3:0] = (ext_mem_addr_out & ~s) | (gp_hi_out & s);
      cmp(32'({addr_pin_oe, addr_pin_out}), 32'(e));
      cmp(32'(gp_hi_in), 32'(addr_pin_in & s));
    end
  endtask

  // Distinct patterns at time zero keep every lane tellable apart.
  initial begin
    reg_addr         = 16'h0;
    reg_wdata        = 16'h0;
    reg_wr           = 1'b0;
    reg_rd           = 1'b0;
    card_out         = 6'h2a;
    card_oe          = 6'h15;
    audio_out        = 4'h9;
    audio_oe         = 4'h6;
    gpio_out         = 6'h33;
    gpio_oe          = 6'h0c;
    bsp_out          = 6'h1d;
    bsp_oe           = 6'h22;
    sp0_pin_in       = 6'h2d;
    ext_mem_addr_out = 4'h5;
    gp_hi_out        = 4'ha;
    gp_hi_oe         = 4'hc;
    addr_pin_in      = 4'h0;
    t_boot(4'ha);
    t_modes();
    t_regs();
    t_addr();
    t_boot(4'h5);
    results();
  end
endmodule
